//--- logic/nvsc_host.sv
// Function
// - Host keeps busy pin released during accesses
// - Write strobe held high over all six steps
// - Six addresses issued consecutively in order
// - Busy request held low at least 15 ns
`timescale 1ns/1ns
`default_nettype none
module nvsc_host
	import nvsc_pkg::*;
#(
	parameter int STORE_CYC = STORE_DURATION_CYC,
	parameter int RECALL_CYC = SOFT_RECALL_CYC,
	parameter int PWRUP_CYC = POWERUP_RECALL_CYC,
	parameter int LATENCY_CYC = SOFT_COMMAND_LATENCY_CYC,
	parameter int GRACE_CYC = HW_STORE_GRACE_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic reqValid,
	input wire nvsc_pkg::nvsc_cmd_e reqCmd,
	input wire logic [nvsc_pkg::ADDR_W-1:0] reqAddr,
	input wire logic [nvsc_pkg::DATA_W-1:0] reqWdata,
	input wire logic hwStoreReq,
	input wire logic supplyOk,
	output logic reqReady,
	output logic rspValid,
	output logic [nvsc_pkg::DATA_W-1:0] rspRdata,
	output logic nvBusy,
	output logic chipSelN,
	output logic writeN,
	output logic outEnN,
	output logic [nvsc_pkg::ADDR_W-1:0] memAddr,
	output logic [nvsc_pkg::DATA_W-1:0] dqOut,
	output logic dqOe,
	input wire logic [nvsc_pkg::DATA_W-1:0] dqIn,
	output logic storeRequestBusyNOut,
	output logic storeRequestBusyNOe,
	input wire logic storeRequestBusyNIn
);
	import nvsc_pkg::*;
	typedef enum logic [3:0] {
		S_PWRUP = 4'h0,
		S_IDLE = 4'h1,
		S_ACC = 4'h2,
		S_GAP = 4'h3,
		S_SEQ = 4'h4,
		S_SEQGAP = 4'h5,
		S_WAITNV = 4'h6,
		S_HWREQ = 4'h7,
		S_HWWAIT = 4'h8
	} nvsc_state_e;
	// ====================================================
	// Pin synchronisers
	logic [DATA_W-1:0] dqMeta_q, dqSync_q;
	logic busyMeta_q, busySync_q;
	always_ff @(posedge ref_clk) begin
		if (clkEn) begin
			dqMeta_q <= dqIn;
			dqSync_q <= dqMeta_q;
			busyMeta_q <= storeRequestBusyNIn;
			busySync_q <= busyMeta_q;
		end
	end

	// ====================================================
	// Main sequencer
	nvsc_state_e state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [2:0] step_q, step_d;
	nvsc_cmd_e cmd_q, cmd_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic dirty_q, dirty_d, rspV_q, rspV_d, hwPend_q, hwPend_d;
	logic csN_q, csN_d, wN_q, wN_d, oeN_q, oeN_d, dqOe_q, dqOe_d, hsbOe_q, hsbOe_d;
	logic [15:0] seqAddr;
	// Sequence address for the current step
	always_comb begin
		unique case (step_q)
			3'd0: seqAddr = SEQ_A1;
			3'd1: seqAddr = SEQ_A2;
			3'd2: seqAddr = SEQ_A3;
			3'd3: seqAddr = SEQ_A4;
			3'd4: seqAddr = SEQ_A5;
			default: seqAddr = (cmd_q == NVSC_CMD_STORE) ? SEQ_STORE : SEQ_RECALL;
		endcase
	end
	// Next-state logic
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		step_d = step_q;
		cmd_d = cmd_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		dirty_d = dirty_q;
		rspV_d = 1'b0;
		hwPend_d = hwPend_q | hwStoreReq;
		csN_d = csN_q;
		wN_d = wN_q;
		oeN_d = oeN_q;
		dqOe_d = dqOe_q;
		hsbOe_d = hsbOe_q;
		unique case (state_q)
			S_PWRUP: begin
				// Power-up recall window restarts while supply is low
				if (!supplyOk) begin
					cnt_d = '0;
				end else if (cnt_q >= CNT_W'(PWRUP_CYC)) begin
					state_d = S_IDLE;
					dirty_d = 1'b0;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			S_IDLE: begin
				cnt_d = '0;
				if (!supplyOk) begin
					state_d = S_PWRUP; // Low supply blocks access
				end else if (hwPend_q) begin
					// Store request only worth issuing when data changed
					hwPend_d = hwStoreReq; // A fresh request in this cycle wins
					if (dirty_q) begin
						hsbOe_d = 1'b1;
						state_d = S_HWREQ;
					end
				end else if (busySync_q == 1'b0) begin
					state_d = S_HWWAIT; // Device busy on its own store
				end else if (reqValid) begin
					cmd_d = reqCmd;
					addr_d = reqAddr;
					wdata_d = reqWdata;
					if (reqCmd == NVSC_CMD_READ || reqCmd == NVSC_CMD_WRITE) begin
						state_d = S_ACC;
						csN_d = 1'b0;
						wN_d = (reqCmd != NVSC_CMD_WRITE);
						oeN_d = (reqCmd == NVSC_CMD_WRITE); // Avoid contention on writes
						dqOe_d = (reqCmd == NVSC_CMD_WRITE);
						if (reqCmd == NVSC_CMD_WRITE) begin
							dirty_d = 1'b1;
						end
					end else begin
						// Six reads with write strobe high
						step_d = 3'd0;
						state_d = S_SEQGAP;
					end
				end
			end
			S_ACC: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == CNT_W'(ACCESS_CYC - 1)) begin
					rdata_d = dqSync_q;
					csN_d = 1'b1; // Deselect floats the bus
					wN_d = 1'b1;
					oeN_d = 1'b1;
					dqOe_d = 1'b0;
					cnt_d = '0;
					state_d = S_GAP;
				end
			end
			S_GAP: begin
				rspV_d = 1'b1;
				state_d = S_IDLE;
			end
			S_SEQGAP: begin
				// Select falls here, giving the step's sampling edge
				addr_d = {1'b0, seqAddr};
				csN_d = 1'b0;
				oeN_d = 1'b0;
				wN_d = 1'b1;
				cnt_d = '0;
				state_d = S_SEQ;
			end
			S_SEQ: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == CNT_W'(ACCESS_CYC - 1)) begin
					csN_d = 1'b1;
					oeN_d = 1'b1;
					cnt_d = '0;
					if (step_q == 3'd5) begin
						// Final step: bus is floating, no data taken
						state_d = S_WAITNV;
						if (cmd_q == NVSC_CMD_STORE) begin
							dirty_d = 1'b0;
						end
					end else begin
						step_d = step_q + 1'b1; // No writes interleaved
						state_d = S_SEQGAP;
					end
				end
			end
			S_WAITNV: begin
				// Latency plus operation time, I/O held off
				cnt_d = cnt_q + 1'b1;
				if (cmd_q == NVSC_CMD_RECALL) begin
					dirty_d = 1'b0;
				end
				if (cnt_q >= CNT_W'(LATENCY_CYC + ((cmd_q == NVSC_CMD_STORE) ? STORE_CYC : RECALL_CYC))) begin
					rspV_d = 1'b1;
					state_d = S_IDLE;
				end
			end
			S_HWREQ: begin
				// Release after the minimum pulse, then wait out grace
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == CNT_W'(HW_STORE_PULSE_CYC)) begin
					hsbOe_d = 1'b0;
				end
				if (cnt_q >= CNT_W'(GRACE_CYC)) begin
					cnt_d = '0;
					dirty_d = 1'b0;
					state_d = S_HWWAIT;
				end
			end
			S_HWWAIT: begin
				// Busy pin released marks the end of the store
				cnt_d = cnt_q + 1'b1;
				if (busySync_q || cnt_q >= CNT_W'(STORE_CYC)) begin
					cnt_d = '0;
					state_d = S_IDLE;
				end
			end
			default: begin
				state_d = S_IDLE;
			end
		endcase
	end
	// State registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q <= S_PWRUP;
			cmd_q <= NVSC_CMD_READ;
			{cnt_q, step_q, addr_q, wdata_q, rdata_q} <= '0;
			{csN_q, wN_q, oeN_q} <= 3'h7; // Strobes idle high
			{dirty_q, rspV_q, hwPend_q, dqOe_q, hsbOe_q} <= 5'h00;
		end else if (clkEn) begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			step_q <= step_d;
			cmd_q <= cmd_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
			dirty_q <= dirty_d;
			rspV_q <= rspV_d;
			hwPend_q <= hwPend_d;
			csN_q <= csN_d;
			wN_q <= wN_d;
			oeN_q <= oeN_d;
			dqOe_q <= dqOe_d;
			hsbOe_q <= hsbOe_d;
		end
	end

	// ====================================================
	// Outputs, registered
	logic ready_q, busy_q;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			{ready_q, busy_q} <= 2'h1;
		end else if (clkEn) begin
			ready_q <= (state_d == S_IDLE) && !hwPend_d;
			busy_q <= (state_d != S_IDLE);
		end
	end

	assign reqReady = ready_q;
	assign nvBusy = busy_q;
	assign rspValid = rspV_q;
	assign rspRdata = rdata_q;
	assign chipSelN = csN_q;
	assign writeN = wN_q;
	assign outEnN = oeN_q;
	assign memAddr = addr_q;
	assign dqOut = wdata_q;
	assign dqOe = dqOe_q;
	assign storeRequestBusyNOut = 1'b0; // Open drain: only ever pulls low
	assign storeRequestBusyNOe = hsbOe_q;
endmodule
`default_nettype wire

//--- logic/nvsc_pkg.sv
package nvsc_pkg;
	// ====================================================
	// Bus geometry
	localparam int ADDR_W = 17;
	localparam int DATA_W = 8;
	localparam int MATCH_W = 16;
	// ====================================================
	// Command sequence addresses, low 16 bits only
	localparam logic [15:0] SEQ_A1 = 16'h4e38;
	localparam logic [15:0] SEQ_A2 = 16'hb1c7;
	localparam logic [15:0] SEQ_A3 = 16'h83e0;
	localparam logic [15:0] SEQ_A4 = 16'h7c1f;
	localparam logic [15:0] SEQ_A5 = 16'h703f;
	localparam logic [15:0] SEQ_STORE = 16'h8fc0;
	localparam logic [15:0] SEQ_RECALL = 16'h4c63;
	// ====================================================
	// Timing, clock 50 MHz
	localparam int CLK_MHZ = 50;
	localparam int CLK_NS = 20;
	localparam int ACCESS_NS = 60;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam int HW_STORE_PULSE_MIN_NS = 15;
	localparam int HW_STORE_PULSE_CYC = (HW_STORE_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int SOFT_COMMAND_LATENCY_US = 70;
	localparam int SOFT_COMMAND_LATENCY_CYC = SOFT_COMMAND_LATENCY_US * CLK_MHZ;
	localparam int HW_STORE_GRACE_TIME_US = 70;
	localparam int HW_STORE_GRACE_CYC = HW_STORE_GRACE_TIME_US * CLK_MHZ;
	localparam int STORE_DURATION_US_COM = 12500;
	localparam int STORE_DURATION_US_IND = 15000;
	localparam int STORE_DURATION_CYC = STORE_DURATION_US_IND * CLK_MHZ;
	localparam int SOFT_RECALL_DURATION_US = 100;
	localparam int SOFT_RECALL_CYC = SOFT_RECALL_DURATION_US * CLK_MHZ;
	localparam int POWERUP_RECALL_DURATION_MS = 40;
	localparam int POWERUP_RECALL_CYC = POWERUP_RECALL_DURATION_MS * 1000 * CLK_MHZ;
	localparam int CNT_W = 32;
	// ====================================================
	// Command codes
	typedef enum logic [1:0] {
		NVSC_CMD_READ = 2'b00,
		NVSC_CMD_WRITE = 2'b01,
		NVSC_CMD_STORE = 2'b10,
		NVSC_CMD_RECALL = 2'b11
	} nvsc_cmd_e;
endpackage

//--- bench/nvsc_host_sva.sv
`timescale 1ns/1ns
`default_nettype none
module nvsc_host_sva (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic reqValid,
	input wire nvsc_pkg::nvsc_cmd_e reqCmd,
	input wire logic reqReady,
	input wire logic supplyOk,
	input wire logic rspValid,
	input wire logic chipSelN,
	input wire logic writeN,
	input wire logic outEnN,
	input wire logic [nvsc_pkg::ADDR_W-1:0] memAddr,
	input wire logic dqOe,
	input wire logic storeRequestBusyNOe
);
	import nvsc_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ====
	// Access phases
	sequence s_take(c);
		reqValid && reqReady && supplyOk && reqCmd == c;
	endsequence
	sequence s_read;
		(!chipSelN && !outEnN && writeN) [*3] ##1 chipSelN;
	endsequence
	sequence s_write;
		(!chipSelN && !writeN && outEnN && dqOe) [*3];
	endsequence
	// ====
	// Bus rules
	a_busy_released: assert property (!chipSelN |-> !storeRequestBusyNOe)
		else $error("busy pin pulled during access");
	a_read_resp: assert property (s_take(NVSC_CMD_READ) |-> ##5 rspValid)
		else $error("read answer late");
	a_read_strobe: assert property (s_take(NVSC_CMD_READ) |=> s_read)
		else $error("read strobes wrong");
	a_write_strobe: assert property (s_take(NVSC_CMD_WRITE) |=> s_write)
		else $error("write strobes wrong");
	a_seq_no_write: assert property (s_take(NVSC_CMD_STORE) |=> writeN [*8])
		else $error("write strobe in sequence");
	a_pulse_min: assert property ($rose(storeRequestBusyNOe) |-> storeRequestBusyNOe [*2])
		else $error("store request too short");
	a_addr_steady: assert property (!chipSelN && $past(!chipSelN) |-> $stable(memAddr))
		else $error("address moved in strobe");
	a_host_float: assert property (!outEnN |-> !dqOe)
		else $error("host drives data in read");
endmodule
bind nvsc_host nvsc_host_sva i_nvsc_host_sva (.ref_clk, .rst, .reqValid, .reqCmd, .reqReady,
	.supplyOk, .rspValid, .chipSelN, .writeN, .outEnN, .memAddr, .dqOe, .storeRequestBusyNOe);
`default_nettype wire

//--- bench/nvsc_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
module nvsc_dev_model
	import nvsc_pkg::*;
#(
	parameter int BUSY_CYC = 15
) (
	input wire logic clk,
	input wire logic csN,
	input wire logic wN,
	input wire logic oeN,
	input wire logic [16:0] addr,
	input wire logic [7:0] din,
	input wire logic pin,
	output logic [7:0] dout,
	output logic devPull = 0
);
	logic [7:0] mem [256], nv [256];
	logic [7:0] junk = 8'h5a;
	logic [15:0] steps [5] = '{SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4, SEQ_A5};
	int step = 0, busy = 0;
	logic dirty = 0, rdLast = 0;
	// ====
	// Mode decode, locked out while busy
	wire logic rd = !csN && !oeN && wN && pin && busy == 0;
	wire logic wr = !csN && !wN && pin && busy == 0;
	wire logic [15:0] a = addr[15:0];
	// Released bus toggles so stale data never passes
	assign dout = rd ? mem[addr[7:0]] : junk;
	// Array, sequence detector and nonvolatile cycles
	always @(posedge clk) begin
		junk <= ~junk;
		rdLast <= rd;
		if (busy > 0) begin
			busy <= busy - 1;
			devPull <= busy > 1 && devPull;
		end else if (wr) begin
			mem[addr[7:0]] <= din;
			dirty <= 1;
			step <= 0;
		end else if (rd && !rdLast) begin
			if (step == 5 && (a == SEQ_STORE || a == SEQ_RECALL)) begin
				busy <= BUSY_CYC;
				devPull <= a == SEQ_STORE;
				if (a == SEQ_STORE) nv <= mem;
				else mem <= nv;
				dirty <= 0;
				step <= 0;
			end else begin
				step <= (step < 5 && a == steps[step]) ? step + 1 : int'(a == SEQ_A1);
			end
		end else if (!pin && !devPull && dirty) begin
			busy <= BUSY_CYC;
			devPull <= 1;
			nv <= mem;
			dirty <= 0;
		end
	end
endmodule
`default_nettype wire

//--- bench/nvsc_host_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin fails++; \
	$display("MISMATCH %s exp %h got %h", n, e, a); end end
module nvsc_host_tb;
	import nvsc_pkg::*;
	logic ref_clk = 0, rst = 1, reqValid = 0, hwStoreReq = 0, supplyOk = 1, clkEn = 1;
	nvsc_cmd_e reqCmd = NVSC_CMD_READ;
	logic [16:0] reqAddr = '0, memAddr;
	logic [7:0] reqWdata = '0, rd, rspRdata, dqOut, devDq;
	logic reqReady, rspValid, nvBusy, chipSelN, writeN, outEnN, dqOe, busyOe, busyOut, devPull;
	wire logic [7:0] dq = dqOe ? dqOut : devDq;
	// Open-drain pin with pull-up
	wire logic busyPin = !devPull && (!busyOe || busyOut);
	int fails = 0, cmp_count = 0, cyc = 0, n = 0, pulls = 0;
	always #10 ref_clk = ~ref_clk;
	// Short counts keep the run brief
	nvsc_host #(.STORE_CYC(20), .RECALL_CYC(20), .PWRUP_CYC(20), .LATENCY_CYC(20),
		.GRACE_CYC(20)) i_nvsc_host (.ref_clk, .rst, .clkEn, .reqValid, .reqCmd,
		.reqAddr, .reqWdata, .hwStoreReq, .supplyOk, .reqReady, .rspValid, .rspRdata, .nvBusy,
		.chipSelN, .writeN, .outEnN, .memAddr, .dqOut, .dqOe, .dqIn(dq),
		.storeRequestBusyNOut(busyOut), .storeRequestBusyNOe(busyOe),
		.storeRequestBusyNIn(busyPin));
	nvsc_dev_model i_nvsc_dev_model (.clk(ref_clk), .csN(chipSelN), .wN(writeN),
		.oeN(outEnN), .addr(memAddr), .din(dq), .pin(busyPin), .dout(devDq), .devPull);
	// ====
	// Closing and watchdog
	task automatic give_verdict;
		if (fails == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			give_verdict;
		end
	end
	// Counts cycles the device holds the pin
	always @(negedge ref_clk) if (devPull) pulls++;
	// ====
	// Bus tasks
	task automatic wait_ready(output int k);
		k = 0;
		while (reqReady !== 1'b1 && k < 300) begin
			@(negedge ref_clk);
			k++;
		end
		`CHK("ready", 1'b1, reqReady)
	endtask
	task automatic req(input nvsc_cmd_e c, input logic [16:0] a, input logic [7:0] w);
		int k;
		wait_ready(k);
		reqCmd = c;
		reqAddr = a;
		reqWdata = w;
		reqValid = 1;
		@(negedge ref_clk);
		reqValid = 0;
		k = 0;
		while (rspValid !== 1'b1 && k < 300) begin
			@(negedge ref_clk);
			k++;
		end
		`CHK("answer", 1'b1, rspValid)
		rd = rspRdata;
		@(negedge ref_clk);
	endtask
	// ====
	// Scenarios
	task automatic t_power;
		wait_ready(n);
		`CHK("pwrup wait", 1'b1, n >= 20)
		supplyOk = 0;
		repeat (4) @(negedge ref_clk);
		`CHK("low supply ready", 1'b0, reqReady)
		`CHK("low supply busy", 1'b1, nvBusy)
		// Freeze across the supply return: the recall count must not advance
		clkEn = 0;
		supplyOk = 1;
		repeat (10) @(negedge ref_clk);
		clkEn = 1;
		wait_ready(n);
		`CHK("recall wait", 1'b1, n >= 20)
		`CHK("idle busy", 1'b0, nvBusy)
	endtask
	task automatic t_rw;
		for (int i = 0; i < 3; i++) req(NVSC_CMD_WRITE, {i[0], 16'h20 + 16'(i)}, 8'hc0 + 8'(i));
		for (int i = 0; i < 3; i++) begin
			req(NVSC_CMD_READ, {i[0], 16'h20 + 16'(i)}, 8'h00);
			`CHK("read back", 8'hc0 + 8'(i), rd)
		end
	endtask
	task automatic t_soft;
		req(NVSC_CMD_WRITE, 17'h40, 8'ha5);
		n = pulls;
		req(NVSC_CMD_STORE, 17'h0, 8'h00);
		`CHK("store busy", 1'b1, pulls > n)
		req(NVSC_CMD_WRITE, 17'h40, 8'h3c);
		req(NVSC_CMD_RECALL, 17'h0, 8'h00);
		req(NVSC_CMD_READ, 17'h40, 8'h00);
		`CHK("soft restore", 8'ha5, rd)
	endtask
	task automatic t_hw;
		req(NVSC_CMD_WRITE, 17'h41, 8'h77);
		hwStoreReq = 1;
		@(negedge ref_clk);
		hwStoreReq = 0;
		req(NVSC_CMD_WRITE, 17'h41, 8'h11);
		req(NVSC_CMD_RECALL, 17'h0, 8'h00);
		req(NVSC_CMD_READ, 17'h41, 8'h00);
		`CHK("hw restore", 8'h77, rd)
		hwStoreReq = 1;
		@(negedge ref_clk);
		hwStoreReq = 0;
		n = 0;
		repeat (30) @(negedge ref_clk) n += int'(busyOe);
		`CHK("clean skip", 0, n)
	endtask
	initial begin
		repeat (10) @(negedge ref_clk);
		rst = 0;
		t_power;
		t_rw;
		t_soft;
		t_hw;
		give_verdict;
	end
endmodule
`default_nettype wire
